/* File: rtl/six_bit_io_port_nine.sv */
// Contract
// - six bidirectional pins with serial and irq
// - map both serial channels onto pins
// - irq inputs gated only by enables
// - same pin functions in every mode
// - write-only direction register at FFD0
// - read/write data register FFD2, reset C0
// - decode only lower sixteen address bits
// - direction bits seven, six read one
// - direction one output, zero input
// - direction register reads all ones
// - direction resets C0, kept in soft standby
// - outputs keep driving in software standby
// - output from data; read data or pin
// - data bits seven, six fixed one
// - receive enable makes pin an input
`timescale 1ns/1ns
`default_nettype none
module six_bit_io_port_nine
  import io_port_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // standby controls
  input wire logic hw_standby,
  input wire logic sw_standby,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // serial channel zero
  input wire logic serial0_transmit_line,
  output logic serial0_receive_line,
  input wire logic serial0_clock_out,
  output logic serial0_clock_in,
  // serial channel one
  input wire logic serial1_transmit_line,
  output logic serial1_receive_line,
  input wire logic serial1_clock_out,
  output logic serial1_clock_in,
  // interrupt requests to controller
  output logic external_request_four,
  output logic external_request_five,
  // pins
  input wire logic [5:0] pin_in,
  output logic [5:0] pin_out,
  output logic [5:0] pin_oe_n
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0] dir_q;
  logic [7:0] data_q;
  logic [7:0] serial_ctrl_q;
  logic [1:0] irq_enable_settings_q;
  logic [5:0] pins_synced;
  bus_phase_t phase_q;
  logic [15:0] addr_q;
  logic hit;
  logic [5:0] drive_en;
  logic [5:0] drive_val;
  logic [5:0] port_read;
  logic soft_hold;

  function automatic logic addr_is(input logic [15:0] a, input logic [15:0] off);
    addr_is = (a == off);
  endfunction : addr_is

  pin_sync #(
    .WIDTH(PIN_COUNT)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(pin_in),
    .sync_out(pins_synced)
  );

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (PIN_COUNT != 6)
  begin : g_pin_count_check
    $error("pin count must match the six pin ports");
  end

  // ---------------------------------------------------------------
  // ahb-lite address phase
  // ---------------------------------------------------------------
  assign hit = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  assign soft_hold = sw_standby;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      phase_q <= BUS_IDLE;
      addr_q <= '0;
    end
    else if (hready)
    begin
      phase_q <= hit ? (hwrite ? BUS_WRITE : BUS_READ) : BUS_IDLE;
      addr_q <= haddr[ADDR_LSB_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // pin function selection
  // ---------------------------------------------------------------
  always_comb
  begin
    // general i/o: direction one drives data bit
    drive_en = dir_q[5:0];
    drive_val = data_q[5:0];
    // serial claims override general i/o
    if (serial_ctrl_q[SC_TE0])
    begin
      drive_en[PIN_TX0] = 1'b1;
      drive_val[PIN_TX0] = serial0_transmit_line;
    end
    if (serial_ctrl_q[SC_TE1])
    begin
      drive_en[PIN_TX1] = 1'b1;
      drive_val[PIN_TX1] = serial1_transmit_line;
    end
    if (serial_ctrl_q[SC_RE0])
    begin
      drive_en[PIN_RX0] = 1'b0;
    end
    if (serial_ctrl_q[SC_RE1])
    begin
      drive_en[PIN_RX1] = 1'b0;
    end
    if (serial_ctrl_q[SC_CKI0])
    begin
      drive_en[PIN_CK0] = 1'b0;
    end
    else if (serial_ctrl_q[SC_CKO0])
    begin
      drive_en[PIN_CK0] = 1'b1;
      drive_val[PIN_CK0] = serial0_clock_out;
    end
    if (serial_ctrl_q[SC_CKI1])
    begin
      drive_en[PIN_CK1] = 1'b0;
    end
    else if (serial_ctrl_q[SC_CKO1])
    begin
      drive_en[PIN_CK1] = 1'b1;
      drive_val[PIN_CK1] = serial1_clock_out;
    end
  end

  // read path: direction one returns data, zero returns pin
  always_comb
  begin
    for (int i = 0; i < PIN_COUNT; i++)
    begin
      port_read[i] = dir_q[i] ? data_q[i] : pins_synced[i];
    end
  end

  // ---------------------------------------------------------------
  // direction register
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dir_q <= DIR_RESET;
    end
    else if (hw_standby)
    begin
      dir_q <= DIR_RESET;
    end
    else if (!soft_hold && phase_q == BUS_WRITE && addr_is(addr_q, DIR_OFFSET))
    begin
      dir_q <= hwdata[7:0] | RESERVED_MASK;
    end
  end

  // ---------------------------------------------------------------
  // data register
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      data_q <= DATA_RESET;
    end
    else if (hw_standby)
    begin
      data_q <= DATA_RESET;
    end
    else if (!soft_hold && phase_q == BUS_WRITE && addr_is(addr_q, DATA_OFFSET))
    begin
      data_q <= hwdata[7:0] | RESERVED_MASK;
    end
  end

  // ---------------------------------------------------------------
  // serial claim register
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      serial_ctrl_q <= '0;
    end
    else if (hw_standby)
    begin
      serial_ctrl_q <= '0;
    end
    else if (!soft_hold && phase_q == BUS_WRITE && addr_is(addr_q, SERIAL_CTRL_OFFSET))
    begin
      serial_ctrl_q <= hwdata[7:0];
    end
  end

  // ---------------------------------------------------------------
  // irq enable register
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_enable_settings_q <= '0;
    end
    else if (hw_standby)
    begin
      irq_enable_settings_q <= '0;
    end
    else if (!soft_hold && phase_q == BUS_WRITE && addr_is(addr_q, IRQ_CTRL_OFFSET))
    begin
      irq_enable_settings_q <= hwdata[1:0];
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= '0;
    end
    else if (hit && !hwrite)
    begin
      case (haddr[ADDR_LSB_W-1:0])
        DIR_OFFSET: hrdata <= {24'h000000, DIR_READ_VALUE};
        DATA_OFFSET: hrdata <= {24'h000000, RESERVED_MASK | {2'h0, port_read}};
        SERIAL_CTRL_OFFSET: hrdata <= {24'h000000, serial_ctrl_q};
        IRQ_CTRL_OFFSET: hrdata <= {30'h00000000, irq_enable_settings_q};
        PIN_STATUS_OFFSET: hrdata <= {26'h0000000, pins_synced};
        default: hrdata <= '0;
      endcase
    end
    else
    begin
      hrdata <= '0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // pin drivers and function outputs
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_out <= '0;
      pin_oe_n <= '1;
    end
    else
    begin
      // software standby retains registers, so outputs keep driving
      pin_out <= drive_val;
      pin_oe_n <= ~drive_en;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      serial0_receive_line <= 1'b1;
      serial1_receive_line <= 1'b1;
      serial0_clock_in <= 1'b0;
      serial1_clock_in <= 1'b0;
    end
    else
    begin
      serial0_receive_line <= pins_synced[PIN_RX0];
      serial1_receive_line <= pins_synced[PIN_RX1];
      serial0_clock_in <= pins_synced[PIN_CK0];
      serial1_clock_in <= pins_synced[PIN_CK1];
    end
  end

  // ---------------------------------------------------------------
  // interrupt request outputs
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      external_request_four <= 1'b0;
      external_request_five <= 1'b0;
    end
    else
    begin
      // active-low pin level, independent of direction
      external_request_four <= irq_enable_settings_q[IRQ_EN4] & ~pins_synced[PIN_CK0];
      external_request_five <= irq_enable_settings_q[IRQ_EN5] & ~pins_synced[PIN_CK1];
    end
  end

endmodule : six_bit_io_port_nine
`default_nettype wire

/* File: rtl/io_port_pkg.sv */
`default_nettype none
package io_port_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [15:0] DIR_OFFSET = 16'hFFD0;
  localparam logic [15:0] DATA_OFFSET = 16'hFFD2;
  localparam logic [15:0] SERIAL_CTRL_OFFSET = 16'hFFD4;
  localparam logic [15:0] IRQ_CTRL_OFFSET = 16'hFFD8;
  localparam logic [15:0] PIN_STATUS_OFFSET = 16'hFFDC;
  localparam int ADDR_LSB_W = 16;

  // ---------------------------------------------------------------
  // reset values and field layout
  // ---------------------------------------------------------------
  localparam logic [7:0] DIR_RESET = 8'hC0;
  localparam logic [7:0] DATA_RESET = 8'hC0;
  localparam logic [7:0] RESERVED_MASK = 8'hC0;
  localparam logic [7:0] DIR_READ_VALUE = 8'hFF;
  localparam int PIN_COUNT = 6;

  // serial control bits
  localparam int SC_TE0 = 0;
  localparam int SC_RE0 = 1;
  localparam int SC_CKO0 = 2;
  localparam int SC_CKI0 = 3;
  localparam int SC_TE1 = 4;
  localparam int SC_RE1 = 5;
  localparam int SC_CKO1 = 6;
  localparam int SC_CKI1 = 7;

  // pin positions
  localparam int PIN_TX0 = 0;
  localparam int PIN_TX1 = 1;
  localparam int PIN_RX0 = 2;
  localparam int PIN_RX1 = 3;
  localparam int PIN_CK0 = 4;
  localparam int PIN_CK1 = 5;

  // irq enable bits
  localparam int IRQ_EN4 = 0;
  localparam int IRQ_EN5 = 1;

  // ---------------------------------------------------------------
  // bus constants
  // ---------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WRITE = 2'b01,
    BUS_READ = 2'b11
  } bus_phase_t;

endpackage : io_port_pkg
`default_nettype wire

/* File: rtl/pin_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module pin_sync
  import io_port_pkg::*;
#(
  parameter int WIDTH = 6
)
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  if (WIDTH < 1)
  begin : g_width_check
    $error("synchroniser width must be at least one");
  end

  // ---------------------------------------------------------------
  // two-stage synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_q <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : pin_sync
`default_nettype wire

/* File: test/pn_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module pn_checker
  import io_port_pkg::*;
(
  // clock, reset, standby
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hw_standby,
  input wire logic sw_standby,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // pins
  input wire logic serial0_receive_line,
  input wire logic external_request_four,
  input wire logic [5:0] pin_in,
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe_n
);
  logic rd_take;
  assign rd_take = hsel && hready && htrans[1] && !hwrite;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  property p_okay; hreadyout && !hresp; endproperty
  property p_dir_rd; rd_take && haddr[15:0] == DIR_OFFSET |=> hrdata == 32'h000000FF; endproperty
  property p_data_rd; rd_take && haddr[15:0] == DATA_OFFSET |=> hrdata[7:6] == 2'b11; endproperty
  property p_rst; $rose(hresetn) |-> pin_oe_n == 6'h3F; endproperty
  property p_hw; hw_standby [*3] |-> pin_oe_n == 6'h3F; endproperty
  property p_sw; sw_standby [*3] |=> $stable(pin_out) && $stable(pin_oe_n); endproperty
  property p_irq; pin_in[4] [*5] |=> !external_request_four; endproperty
  property p_rx; $stable(pin_in[2]) [*4] |=> serial0_receive_line == $past(pin_in[2]); endproperty
  a_okay: assert property (p_okay) else $error("bus not ready or not okay");
  a_dir_rd: assert property (p_dir_rd) else $error("direction read not all ones");
  a_data_rd: assert property (p_data_rd) else $error("data bits 7:6 not one");
  a_rst: assert property (p_rst) else $error("pins driven after reset");
  a_hw: assert property (p_hw) else $error("pins driven in hardware standby");
  a_sw: assert property (p_sw) else $error("pin drive moved in software standby");
  a_irq: assert property (p_irq) else $error("request with pin high");
  a_rx: assert property (p_rx) else $error("receive line not pin level");
  c_dir_rd: cover property (p_dir_rd);
  c_sw: cover property (sw_standby [*3]);
  c_irq: cover property (external_request_four);
endmodule : pn_checker
bind six_bit_io_port_nine pn_checker chk_inst (.hclk, .hresetn, .hw_standby, .sw_standby, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .serial0_receive_line, .external_request_four,
  .pin_in, .pin_out, .pin_oe_n);
`default_nettype wire

/* File: test/pin_world.sv */
`timescale 1ns/1ns
`default_nettype none
module pin_world (
  // pads
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe_n,
  input wire logic [5:0] ext_level,
  output logic [5:0] pin_in
);
  // released pins show the outside level
  assign pin_in = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
endmodule : pin_world
`default_nettype wire

/* File: test/test_six_bit_io_port_nine.sv */
`timescale 1ns/1ns
`default_nettype none
module test_six_bit_io_port_nine
  import io_port_pkg::*;
;
  logic hclk = 1'b0, hresetn = 1'b0, hw_standby = 1'b0, sw_standby = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic hready, hreadyout, hresp, external_request_four, external_request_five;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, seed = 32'h7617, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic serial0_transmit_line = 1'b1, serial1_transmit_line = 1'b0, serial0_clock_out = 1'b1;
  logic serial1_clock_out = 1'b0, serial0_receive_line, serial1_receive_line, serial0_clock_in, serial1_clock_in;
  logic [5:0] pin_in, pin_out, pin_oe_n, ext = 6'h15;
  logic [7:0] dir, val;
  logic [7:0] ctl [3] = '{8'h33, 8'h77, 8'hFF};
  logic [5:0] oe_x [3] = '{6'h0C, 6'h0C, 6'h3C};
  logic [5:0] out_x [3] = '{6'h21, 6'h11, 6'h01};
  int errors = 0, cmp_count = 0, cycles = 0;
  six_bit_io_port_nine six_bit_io_port_nine_inst (.hclk, .hresetn, .hw_standby, .sw_standby, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hready, .hwdata, .hrdata, .hreadyout, .hresp, .serial0_transmit_line,
    .serial0_receive_line, .serial0_clock_out, .serial0_clock_in, .serial1_transmit_line, .serial1_receive_line,
    .serial1_clock_out, .serial1_clock_in, .external_request_four, .external_request_five, .pin_in, .pin_out,
    .pin_oe_n);
  pin_world pin_world_inst (.pin_out, .pin_oe_n, .ext_level(ext), .pin_in);
  assign hready = hreadyout;
  initial
  begin
    forever #50 hclk = ~hclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [31:0] port_rd(input logic [7:0] d, input logic [7:0] v, input logic [5:0] e);
    return {24'h0, 8'hC0 | (((d & v) | (~d & {2'b00, e})) & 8'h3F)};
  endfunction : port_rd
  task automatic print_verdict();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input string what, input logic [31:0] x, input logic [31:0] got);
    cmp_count++;
    if (got !== x)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, x, got);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    htrans <= HTRANS_NONSEQ;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : bus
  task automatic settle();
    repeat (6) @(posedge hclk);
  endtask : settle
  task automatic irq_step(input logic [31:0] a, input logic [31:0] d, input logic [1:0] x);
    bus(1'b1, a, d);
    settle();
    chk("irq", {30'h0, x}, {30'h0, external_request_five, external_request_four});
  endtask : irq_step
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    settle();
    bus(1'b0, 32'hFFD0, 32'h0);
    chk("dir", 32'hFF, rd);
    bus(1'b0, 32'hFFD2, 32'h0);
    chk("data", port_rd(8'hC0, 8'hC0, ext), rd);
    for (int i = 0; i < 24; i++)
    begin
      seed = lfsr(seed);
      dir = (i == 0) ? 8'h3F : (i == 1) ? 8'h00 : seed[7:0];
      val = (i == 0) ? 8'h00 : seed[15:8];
      ext <= seed[21:16];
      bus(1'b1, {seed[31:16], DIR_OFFSET}, {seed[31:8], dir});
      bus(1'b1, {seed[15:0], DATA_OFFSET}, {seed[23:0], val});
      settle();
      bus(1'b0, {seed[23:8], DATA_OFFSET}, 32'h0);
      chk("data", port_rd(dir, val, ext), rd);
      chk("oe", {26'h0, ~dir[5:0]}, {26'h0, pin_oe_n});
      chk("out", {26'h0, val[5:0] & dir[5:0]}, {26'h0, pin_out & dir[5:0]});
    end
    bus(1'b1, 32'hFFD0, 32'h3F);
    bus(1'b1, 32'hFFD2, 32'h2A);
    for (int i = 0; i < 3; i++)
    begin
      bus(1'b1, 32'hFFD4, {24'h0, ctl[i]});
      settle();
      chk("soe", {26'h0, oe_x[i]}, {26'h0, pin_oe_n});
      chk("sout", {26'h0, out_x[i]}, {26'h0, pin_out & ~oe_x[i]});
      chk("rx", {30'h0, ext[3:2]}, {30'h0, serial1_receive_line, serial0_receive_line});
      chk("ckin", {30'h0, (out_x[i][5:4] & ~oe_x[i][5:4]) | (ext[5:4] & oe_x[i][5:4])},
        {30'h0, serial1_clock_in, serial0_clock_in});
    end
    bus(1'b0, 32'hFFD4, 32'h0);
    chk("ctl", 32'hFF, rd);
    bus(1'b1, 32'hFFD4, 32'h0);
    bus(1'b1, 32'hFFD0, 32'h0);
    ext <= 6'h00;
    irq_step(32'hFFD8, 32'h3, 2'h3);
    bus(1'b0, 32'hFFD8, 32'h0);
    chk("irq en", 32'h3, rd);
    irq_step(32'hFFD0, 32'h3F, 2'h1);
    bus(1'b0, 32'hFFDC, 32'h0);
    chk("status", 32'h2A, rd);
    irq_step(32'hFFD2, 32'h0, 2'h3);
    irq_step(32'hFFD8, 32'h0, 2'h0);
    sw_standby <= 1'b1;
    bus(1'b1, 32'hFFD2, 32'h15);
    bus(1'b1, 32'hFFD0, 32'h0);
    settle();
    bus(1'b0, 32'hFFD2, 32'h0);
    chk("sw data", 32'hC0, rd);
    chk("sw oe", 32'h0, {26'h0, pin_oe_n});
    sw_standby <= 1'b0;
    bus(1'b1, 32'hFFD2, 32'h15);
    hw_standby <= 1'b1;
    settle();
    hw_standby <= 1'b0;
    settle();
    bus(1'b0, 32'hFFD2, 32'h0);
    chk("hw data", port_rd(8'hC0, 8'hC0, ext), rd);
    chk("hw oe", 32'h3F, {26'h0, pin_oe_n});
    bus(1'b1, 32'hFFD6, 32'hFF);
    bus(1'b0, 32'hFFD6, 32'h0);
    chk("unmapped", 32'h0, rd);
    print_verdict();
  end
endmodule : test_six_bit_io_port_nine
`default_nettype wire
